// file: hdl/cam_pkg.sv
// Constants for the client access list matcher.
// Assumes a single 100 MHz clock and an AXI4-Lite register master.
package cam_pkg;
  // ==========================================================
  // Sizes
  localparam int CAM_MAX_ENTRIES = 10;
  localparam int CAM_ADDR_W = 8;
  localparam int CAM_IDX_W = 4;
  localparam int CAM_CFG_W = 9;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CAM_CTRL_OFS = 8'h00;
  localparam logic [7:0] CAM_STATUS_OFS = 8'h04;
  localparam logic [3:0] CAM_ENTRY_BASE = 4'h1;
  localparam logic [1:0] CAM_W_ADDR = 2'h0;
  localparam logic [1:0] CAM_W_MASK = 2'h1;
  localparam logic [1:0] CAM_W_CFG = 2'h2;

  // CTRL fields
  localparam int CAM_CTRL_EN_BIT = 0;
  localparam int CAM_CTRL_COMMIT_BIT = 1;
  localparam int CAM_CTRL_OPCM_BIT = 2;
  localparam logic [2:0] CAM_CTRL_RST = 3'h0;

  // Entry config fields
  localparam int CAM_CFG_PROTO_LSB = 0;
  localparam int CAM_CFG_PORT_LSB = 4;
  localparam int CAM_CFG_LVL_LSB = 6;
  localparam int CAM_CFG_VALID_BIT = 8;

  // ==========================================================
  // Codes
  localparam logic [1:0] CAM_PROTO_ENG = 2'h0;
  localparam logic [1:0] CAM_PROTO_SYSACC = 2'h1;
  localparam logic [1:0] CAM_PROTO_OPC = 2'h2;
  localparam logic [1:0] CAM_PROTO_OTHER = 2'h3;
  localparam logic [1:0] CAM_LVL_DENY = 2'h0;
  localparam logic [1:0] CAM_LVL_RO = 2'h1;
  localparam logic [1:0] CAM_LVL_RW = 2'h2;
  localparam logic [1:0] CAM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CAM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CAM_IDLE, CAM_WALK, CAM_DONE} cam_state_t;
endpackage : cam_pkg

// file: hdl/cam_matcher.sv
// Client access list matcher: ordered table walk with staged and active tables.
// Assumes AXI4-Lite master on CORE_CLK, request source and serial config on the same clock.
//
// Contract
// - Walk entries in order, first to last
// - First matching entry decides; stop walking
// - No match at end means deny
// - Masked address bits must agree
// - Zero address and mask match everyone
// - Protocol and port must be selected
// - OPC on first port always denied
// - OPC-only first-port-only entry has no effect
// - OPC models deny system access on second port
// - Entry applies deny, read only, read/write
// - Edited table waits for commit download
// - Open connections keep their earlier level
// - Serial path reconfigures table without list
// - All-ones mask matches single address only
// - At most ten entries
// - List disabled gives system access write; an active OPC models bit still denies system access on second port
`timescale 1ns/100ps
module cam_matcher
  import cam_pkg::*;
#(
  parameter int NUM_ENTRIES = CAM_MAX_ENTRIES
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic [CAM_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [CAM_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic SER_WE,
  input wire logic [CAM_ADDR_W-1:0] SER_ADDR,
  input wire logic [31:0] SER_WDATA,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic [31:0] REQ_IP,
  input wire logic [1:0] REQ_PROTO,
  input wire logic REQ_PORT,
  output logic RSP_VALID,
  output logic [1:0] RSP_LEVEL,
  output logic RSP_HIT,
  output logic [CAM_IDX_W-1:0] RSP_INDEX
);

  // ==========================================================
  // Elaboration check
  if (NUM_ENTRIES < 1 || NUM_ENTRIES > CAM_MAX_ENTRIES) begin : g_bad_size
    $error("NUM_ENTRIES must be 1 to 10");
  end

  localparam logic [CAM_IDX_W-1:0] LAST_IDX = CAM_IDX_W'(NUM_ENTRIES - 1);

  // ==========================================================
  // Storage
  // Staged table is what software edits; active table governs admission
  logic [31:0] stg_ip_r [NUM_ENTRIES];
  logic [31:0] stg_mask_r [NUM_ENTRIES];
  logic [CAM_CFG_W-1:0] stg_cfg_r [NUM_ENTRIES];
  logic [31:0] act_ip_r [NUM_ENTRIES];
  logic [31:0] act_mask_r [NUM_ENTRIES];
  logic [CAM_CFG_W-1:0] act_cfg_r [NUM_ENTRIES];
  logic [2:0] ctrl_r;
  logic act_en_r;
  logic act_opcm_r;
  logic commit_pend_r;

  // ==========================================================
  // AXI4-Lite channel state
  logic aw_have_r;
  logic w_have_r;
  logic [CAM_ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Request walk state
  cam_state_t state_r;
  logic [CAM_IDX_W-1:0] idx_r;
  logic [31:0] req_ip_r;
  logic [1:0] req_proto_r;
  logic req_port_r;
  logic rsp_valid_r;
  logic [1:0] rsp_level_r;
  logic rsp_hit_r;
  logic [CAM_IDX_W-1:0] rsp_index_r;
  logic [1:0] last_level_r;
  logic last_hit_r;
  logic [CAM_IDX_W-1:0] last_index_r;

  // ==========================================================
  // Write path: serial port wins, AXI write waits while SER_WE is high
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  wire axi_wr_fire = aw_have_r && w_have_r && !bvalid_r && !SER_WE;
  wire wr_en = SER_WE || axi_wr_fire;
  wire [CAM_ADDR_W-1:0] wr_addr = SER_WE ? SER_ADDR : aw_addr_r;
  wire [3:0] wr_strb = SER_WE ? 4'hF : w_strb_r;
  wire [31:0] wr_data = SER_WE ? SER_WDATA : w_data_r;
  wire [3:0] wr_ent_raw = wr_addr[7:4] - CAM_ENTRY_BASE;
  wire wr_is_ent = wr_addr[7:4] >= CAM_ENTRY_BASE && wr_ent_raw <= LAST_IDX
                   && wr_addr[3:2] != 2'h3 && wr_addr[1:0] == 2'h0;
  wire wr_is_ctrl = wr_addr == CAM_CTRL_OFS;
  wire wr_is_stat = wr_addr == CAM_STATUS_OFS;
  wire wr_ok = wr_is_ent || wr_is_ctrl || wr_is_stat;
  wire [31:0] ctrl_merged = merge({29'h0, ctrl_r}, wr_data, wr_strb);
  wire commit_req = wr_en && wr_is_ctrl && ctrl_merged[CAM_CTRL_COMMIT_BIT];

  // ==========================================================
  // Staged table and control
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_r <= CAM_CTRL_RST;
    end else if (wr_en && wr_is_ctrl) begin
      ctrl_r <= ctrl_merged[2:0] & 3'h5;
    end
  end

  for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_stage
    wire hit_e = wr_en && wr_is_ent && wr_ent_raw == CAM_IDX_W'(e);
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        stg_ip_r[e] <= 32'h0;
        stg_mask_r[e] <= 32'h0;
        stg_cfg_r[e] <= 9'h000;
      end else if (hit_e) begin
        unique case (wr_addr[3:2])
          CAM_W_ADDR: stg_ip_r[e] <= merge(stg_ip_r[e], wr_data, wr_strb);
          CAM_W_MASK: stg_mask_r[e] <= merge(stg_mask_r[e], wr_data, wr_strb);
          default: stg_cfg_r[e] <= CAM_CFG_W'(merge({23'h0, stg_cfg_r[e]}, wr_data, wr_strb));
        endcase
      end
    end

    // Active copy only moves on commit, and only between walks
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        act_ip_r[e] <= 32'h0;
        act_mask_r[e] <= 32'h0;
        act_cfg_r[e] <= 9'h000;
      end else if (commit_pend_r && state_r == CAM_IDLE) begin
        act_ip_r[e] <= stg_ip_r[e];
        act_mask_r[e] <= stg_mask_r[e];
        act_cfg_r[e] <= stg_cfg_r[e];
      end
    end
  end

  // A new commit request in the apply cycle keeps the flag set
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      commit_pend_r <= 1'b0;
      act_en_r <= 1'b0;
      act_opcm_r <= 1'b0;
    end else begin
      if (commit_pend_r && state_r == CAM_IDLE) begin
        act_en_r <= ctrl_r[CAM_CTRL_EN_BIT];
        act_opcm_r <= ctrl_r[CAM_CTRL_OPCM_BIT];
      end
      commit_pend_r <= commit_req || (commit_pend_r && state_r != CAM_IDLE);
    end
  end

  // Warns software when the staged list would lock out engineering access
  logic [NUM_ENTRIES-1:0] eng_rw_vec;
  for (genvar e = 0; e < NUM_ENTRIES; e++) begin : g_eng
    assign eng_rw_vec[e] = stg_cfg_r[e][CAM_CFG_VALID_BIT] && stg_cfg_r[e][CAM_CFG_PROTO_LSB + 0]
                           && stg_cfg_r[e][CAM_CFG_LVL_LSB +: 2] == CAM_LVL_RW;
  end
  wire no_eng_rw = ctrl_r[CAM_CTRL_EN_BIT] && eng_rw_vec == '0;

  // ==========================================================
  // AXI4-Lite write channels, taken in either order
  assign S_AXI_AWREADY = !aw_have_r;
  assign S_AXI_WREADY = !w_have_r;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= CAM_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end else if (axi_wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (S_AXI_WVALID && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end else if (axi_wr_fire) begin
        w_have_r <= 1'b0;
      end
      if (axi_wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? CAM_RESP_OKAY : CAM_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;

  // ==========================================================
  // AXI4-Lite read channel
  wire [3:0] rd_ent = S_AXI_ARADDR[7:4] - CAM_ENTRY_BASE;
  wire rd_is_ent = S_AXI_ARADDR[7:4] >= CAM_ENTRY_BASE && rd_ent <= LAST_IDX
                   && S_AXI_ARADDR[3:2] != 2'h3 && S_AXI_ARADDR[1:0] == 2'h0;
  wire rd_is_ctrl = S_AXI_ARADDR == CAM_CTRL_OFS;
  wire rd_is_stat = S_AXI_ARADDR == CAM_STATUS_OFS;
  wire [31:0] status_word = {19'h0, last_hit_r, last_index_r, 2'h0, last_level_r,
                             no_eng_rw, state_r != CAM_IDLE, commit_pend_r, act_en_r};
  wire [31:0] ent_word = S_AXI_ARADDR[3:2] == CAM_W_ADDR ? stg_ip_r[rd_ent]
                       : S_AXI_ARADDR[3:2] == CAM_W_MASK ? stg_mask_r[rd_ent]
                       : {23'h0, stg_cfg_r[rd_ent]};
  wire [31:0] rd_word = rd_is_ctrl ? {29'h0, ctrl_r} : rd_is_stat ? status_word
                      : rd_is_ent ? ent_word : 32'h0;
  assign S_AXI_ARREADY = !rvalid_r;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= CAM_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= (rd_is_ctrl || rd_is_stat || rd_is_ent) ? CAM_RESP_OKAY : CAM_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  // ==========================================================
  // Entry test for the entry under the walk pointer
  wire [31:0] cur_ip = act_ip_r[idx_r];
  wire [31:0] cur_mask = act_mask_r[idx_r];
  wire [CAM_CFG_W-1:0] cur_cfg = act_cfg_r[idx_r];
  wire [3:0] cur_protos = cur_cfg[CAM_CFG_PROTO_LSB +: 4];
  wire [1:0] cur_ports = cur_cfg[CAM_CFG_PORT_LSB +: 2];
  wire [1:0] cur_lvl = cur_cfg[CAM_CFG_LVL_LSB +: 2];
  wire addr_ok = ((req_ip_r ^ cur_ip) & cur_mask) == 32'h0;
  wire proto_ok = cur_protos[req_proto_r];
  wire port_ok = cur_ports[req_port_r];
  wire bad_opc = cur_protos == 4'h4 && cur_ports == 2'h1;
  wire bad_sys = act_opcm_r && cur_protos == 4'h2 && cur_ports == 2'h2;
  wire cur_match = cur_cfg[CAM_CFG_VALID_BIT] && addr_ok && proto_ok && port_ok
                   && !bad_opc && !bad_sys;
  // Level code 3 is not a defined level, so it is treated as deny
  wire [1:0] cur_level = cur_lvl == CAM_LVL_RO || cur_lvl == CAM_LVL_RW ? cur_lvl : CAM_LVL_DENY;

  // Requests that never reach the table
  wire in_opc_p1 = REQ_PROTO == CAM_PROTO_OPC && !REQ_PORT;
  wire in_sys_p2 = act_opcm_r && REQ_PROTO == CAM_PROTO_SYSACC && REQ_PORT;
  wire req_take = REQ_VALID && REQ_READY;

  // ==========================================================
  // Walk machine: one entry per cycle
  // Decision is made once per connect; open connections are never revisited
  assign REQ_READY = state_r == CAM_IDLE && !commit_pend_r;
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_r <= CAM_IDLE;
      idx_r <= 4'h0;
      req_ip_r <= 32'h0;
      req_proto_r <= CAM_PROTO_ENG;
      req_port_r <= 1'b0;
      rsp_level_r <= CAM_LVL_DENY;
      rsp_hit_r <= 1'b0;
      rsp_index_r <= 4'h0;
    end else begin
      unique case (state_r)
        CAM_IDLE: begin
          if (req_take) begin
            req_ip_r <= REQ_IP;
            req_proto_r <= REQ_PROTO;
            req_port_r <= REQ_PORT;
            idx_r <= 4'h0;
            rsp_hit_r <= 1'b0;
            rsp_index_r <= 4'h0;
            if (in_opc_p1 || in_sys_p2) begin
              rsp_level_r <= CAM_LVL_DENY;
              state_r <= CAM_DONE;
            end else if (!act_en_r) begin
              rsp_level_r <= CAM_LVL_RW;
              state_r <= CAM_DONE;
            end else begin
              state_r <= CAM_WALK;
            end
          end
        end
        CAM_WALK: begin
          if (cur_match) begin
            rsp_level_r <= cur_level;
            rsp_hit_r <= 1'b1;
            rsp_index_r <= idx_r;
            state_r <= CAM_DONE;
          end else if (idx_r == LAST_IDX) begin
            rsp_level_r <= CAM_LVL_DENY;
            state_r <= CAM_DONE;
          end else begin
            idx_r <= idx_r + 4'h1;
          end
        end
        CAM_DONE: begin
          state_r <= CAM_IDLE;
        end
      endcase
    end
  end

  // Result pulse and last-decision snapshot for software
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rsp_valid_r <= 1'b0;
      last_level_r <= CAM_LVL_DENY;
      last_hit_r <= 1'b0;
      last_index_r <= 4'h0;
    end else begin
      rsp_valid_r <= state_r == CAM_DONE;
      if (state_r == CAM_DONE) begin
        last_level_r <= rsp_level_r;
        last_hit_r <= rsp_hit_r;
        last_index_r <= rsp_index_r;
      end
    end
  end

  assign RSP_VALID = rsp_valid_r;
  assign RSP_LEVEL = rsp_level_r;
  assign RSP_HIT = rsp_hit_r;
  assign RSP_INDEX = rsp_index_r;

  // Protection bits carry no meaning here
  wire unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT};

endmodule : cam_matcher

// file: testbench/cam_matcher_properties.sv
// Checker for the matcher's decision port and read handshake.
// Assumes it is bound to cam_matcher and sees only its ports.
`timescale 1ns/100ps
module cam_matcher_chk
  import cam_pkg::*;
#(
  parameter int NUM_ENTRIES = CAM_MAX_ENTRIES
) (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire logic [1:0] REQ_PROTO,
  input wire logic REQ_PORT,
  input wire logic RSP_VALID,
  input wire logic [1:0] RSP_LEVEL,
  input wire logic RSP_HIT,
  input wire logic [CAM_IDX_W-1:0] RSP_INDEX
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);
  wire logic take = REQ_VALID && REQ_READY;

  AST_WALK_BOUND: assert property (take |-> ##[2:13] RSP_VALID)
    else $error("no decision within the walk bound");
  AST_BUSY: assert property (take |=> !REQ_READY)
    else $error("request taken while a walk runs");
  AST_PULSE: assert property (RSP_VALID |=> !RSP_VALID)
    else $error("decision strobe longer than one cycle");
  AST_HELD: assert property (RSP_VALID |-> $stable({RSP_LEVEL, RSP_HIT, RSP_INDEX}))
    else $error("decision changed under its strobe");
  AST_OPC_FIRST: assert property (take && REQ_PROTO == CAM_PROTO_OPC && !REQ_PORT
    |-> ##[2:3] RSP_VALID && RSP_LEVEL == CAM_LVL_DENY)
    else $error("OPC on first port not denied");
  AST_CODE: assert property (RSP_VALID |-> RSP_LEVEL != 2'h3 && (RSP_HIT || RSP_INDEX == 4'h0))
    else $error("bad level code or miss index");
  AST_RANGE: assert property (RSP_VALID && RSP_HIT |-> RSP_INDEX < NUM_ENTRIES)
    else $error("hit index beyond table");
  AST_AR_ANS: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read not answered next cycle");

  cover property (RSP_VALID && RSP_HIT);
  cover property (RSP_VALID && !RSP_HIT && RSP_LEVEL == CAM_LVL_DENY);
  cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule : cam_matcher_chk

bind cam_matcher cam_matcher_chk #(.NUM_ENTRIES(NUM_ENTRIES)) i_cam_matcher_chk (
  .CORE_CLK, .SRST, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_BVALID, .S_AXI_BREADY,
  .REQ_VALID, .REQ_READY, .REQ_PROTO, .REQ_PORT, .RSP_VALID, .RSP_LEVEL, .RSP_HIT, .RSP_INDEX
);

// file: testbench/cam_client.sv
// Network client model: one connection attempt at a time.
// Assumes the matcher's request handshake on CORE_CLK.
`timescale 1ns/100ps
module cam_client (
  input wire logic CORE_CLK,
  input wire logic REQ_READY,
  input wire logic RSP_VALID,
  input wire logic [1:0] RSP_LEVEL,
  input wire logic RSP_HIT,
  input wire logic [3:0] RSP_INDEX,
  output logic REQ_VALID,
  output logic [31:0] REQ_IP,
  output logic [1:0] REQ_PROTO,
  output logic REQ_PORT
);
  // ==========================================================
  // Request driver
  initial begin
    REQ_VALID = 1'h0;
    REQ_IP = 32'h0;
    REQ_PROTO = 2'h0;
    REQ_PORT = 1'h0;
  end

  task automatic send(input logic [31:0] ip, input logic [1:0] pr, input logic pt,
                      output logic [1:0] l, output logic h, output logic [3:0] x);
    @(posedge CORE_CLK);
    REQ_VALID <= 1'h1;
    REQ_IP <= ip;
    REQ_PROTO <= pr;
    REQ_PORT <= pt;
    do @(posedge CORE_CLK); while (REQ_READY !== 1'h1);
    REQ_VALID <= 1'h0;
    // Released lines flip so stale values cannot pass
    REQ_IP <= ~ip;
    REQ_PROTO <= ~pr;
    REQ_PORT <= ~pt;
    do @(posedge CORE_CLK); while (RSP_VALID !== 1'h1);
    l = RSP_LEVEL;
    h = RSP_HIT;
    x = RSP_INDEX;
  endtask : send
endmodule : cam_client

// file: testbench/test_cam_matcher.sv
// Bench for the access list matcher: AXI4-Lite, serial path, requests.
// Assumes cam_client drives the request port.
`timescale 1ns/100ps
module test_cam_matcher;
  import cam_pkg::*;
  logic CORE_CLK = 1'h0;
  logic SRST = 1'h1;
  logic [7:0] S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0, SER_ADDR = 8'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, SER_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, SER_WE = 1'h0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
  wire logic REQ_VALID, REQ_PORT, REQ_READY, RSP_VALID, RSP_HIT;
  wire logic [31:0] REQ_IP;
  wire logic [1:0] REQ_PROTO, RSP_LEVEL;
  wire logic [3:0] RSP_INDEX;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;

  cam_matcher #(.NUM_ENTRIES(10)) i_cam_matcher (
    .CORE_CLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
    .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .SER_WE, .SER_ADDR, .SER_WDATA, .REQ_VALID,
    .REQ_READY, .REQ_IP, .REQ_PROTO, .REQ_PORT, .RSP_VALID, .RSP_LEVEL, .RSP_HIT, .RSP_INDEX
  );
  cam_client i_cam_client (
    .CORE_CLK, .REQ_READY, .RSP_VALID, .RSP_LEVEL, .RSP_HIT, .RSP_INDEX,
    .REQ_VALID, .REQ_IP, .REQ_PROTO, .REQ_PORT
  );

  // ==========================================================
  // Clock, timeout, tasks
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out;
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_AWREADY === 1'h1) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY === 1'h1) S_AXI_WVALID <= 1'h0;
    end while (S_AXI_BVALID !== 1'h1);
    rs = S_AXI_BRESP;
    S_AXI_BREADY <= 1'h0;
    chk("bresp", {30'h0, CAM_RESP_OKAY}, {30'h0, rs});
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge CORE_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    do begin
      @(posedge CORE_CLK);
      if (S_AXI_ARREADY === 1'h1) S_AXI_ARVALID <= 1'h0;
    end while (S_AXI_RVALID !== 1'h1);
    rd = S_AXI_RDATA;
    rs = S_AXI_RRESP;
    S_AXI_RREADY <= 1'h0;
    chk("rdata", e, rd & m);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask : rchk

  task automatic ser(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    SER_WE <= 1'h1;
    SER_ADDR <= a;
    SER_WDATA <= d;
    @(posedge CORE_CLK);
    SER_WE <= 1'h0;
  endtask : ser

  function automatic logic [31:0] cf(input logic [1:0] l, input logic [1:0] pt, input logic [3:0] pr);
    return {23'h0, 1'h1, l, pt, pr};
  endfunction : cf

  task automatic ent(input logic [3:0] n, input logic [31:0] ip, input logic [31:0] m, input logic [31:0] c);
    wr({n + 4'h1, CAM_W_ADDR, 2'h0}, ip);
    wr({n + 4'h1, CAM_W_MASK, 2'h0}, m);
    wr({n + 4'h1, CAM_W_CFG, 2'h0}, c);
  endtask : ent

  // Index E skips hit and index; F expects a miss
  task automatic rq(input logic [31:0] ip, input logic [1:0] pr, input logic pt, input logic [1:0] el,
                    input logic [3:0] ei);
    logic [1:0] l;
    logic h;
    logic [3:0] x;
    i_cam_client.send(ip, pr, pt, l, h, x);
    chk("level", {30'h0, el}, {30'h0, l});
    if (ei != 4'hE) begin
      chk("hit", {31'h0, ei != 4'hF}, {31'h0, h});
      chk("index", {28'h0, (ei == 4'hF) ? 4'h0 : ei}, {28'h0, x});
    end
  endtask : rq

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge CORE_CLK);
    SRST <= 1'h0;
    rchk(CAM_CTRL_OFS, 32'hFFFFFFFF, 32'h0, CAM_RESP_OKAY);
    rchk(8'hB0, 32'hFFFFFFFF, 32'h0, CAM_RESP_SLVERR);
    rq(32'h0A010203, CAM_PROTO_SYSACC, 1'h1, CAM_LVL_RW, 4'hE);
    rq(32'h0A010203, CAM_PROTO_OPC, 1'h0, CAM_LVL_DENY, 4'hE);
    wr(CAM_CTRL_OFS, 32'h1);
    rchk(CAM_STATUS_OFS, 32'h9, 32'h8, CAM_RESP_OKAY);
    // Most specific first, catch-all last
    ent(4'h0, 32'hCED8010C, 32'hFFFFFF00, cf(CAM_LVL_RW, 2'h2, 4'h1));
    ent(4'h1, 32'hCED8010C, 32'hFFFFFF00, cf(CAM_LVL_RO, 2'h1, 4'h2));
    ent(4'h2, 32'hC0A80105, 32'hFFFFFFFF, cf(CAM_LVL_DENY, 2'h3, 4'h5));
    ent(4'h3, 32'h0, 32'h0, cf(CAM_LVL_RW, 2'h3, 4'hF) & 32'hFF);
    ent(4'h4, 32'h0A000000, 32'hFF000000, cf(CAM_LVL_RW, 2'h1, 4'h4));
    ent(4'h5, 32'hC0A80105, 32'hFFFFFF00, cf(CAM_LVL_RO, 2'h2, 4'h5));
    ent(4'h6, 32'h0, 32'h0, cf(CAM_LVL_DENY, 2'h3, 4'hF));
    rchk(8'h18, 32'h1FF, cf(CAM_LVL_RW, 2'h2, 4'h1), CAM_RESP_OKAY);
    rchk(CAM_STATUS_OFS, 32'h8, 32'h0, CAM_RESP_OKAY);
    rq(32'hCED8014D, CAM_PROTO_ENG, 1'h1, CAM_LVL_RW, 4'hE);
    // Catch-all deny must not act before the commit
    rq(32'h0A010203, CAM_PROTO_OTHER, 1'h1, CAM_LVL_RW, 4'hF);
    wr(CAM_CTRL_OFS, 32'h7);
    rchk(CAM_CTRL_OFS, 32'h2, 32'h0, CAM_RESP_OKAY);
    rq(32'hCED8014D, CAM_PROTO_ENG, 1'h1, CAM_LVL_RW, 4'h0);
    rq(32'hCED8010C, CAM_PROTO_ENG, 1'h0, CAM_LVL_DENY, 4'h6);
    rq(32'hCED8010C, CAM_PROTO_SYSACC, 1'h0, CAM_LVL_RO, 4'h1);
    rq(32'hC0A80105, CAM_PROTO_ENG, 1'h1, CAM_LVL_DENY, 4'h2);
    rq(32'hC0A80106, CAM_PROTO_ENG, 1'h1, CAM_LVL_RO, 4'h5);
    rq(32'hC0A80106, CAM_PROTO_OPC, 1'h1, CAM_LVL_RO, 4'h5);
    rchk(CAM_STATUS_OFS, 32'h1F3F, 32'h1511, CAM_RESP_OKAY);
    rq(32'h0A010203, CAM_PROTO_OPC, 1'h0, CAM_LVL_DENY, 4'hE);
    rq(32'h0A010203, CAM_PROTO_SYSACC, 1'h1, CAM_LVL_DENY, 4'hE);
    rq(32'h0A010203, CAM_PROTO_OTHER, 1'h1, CAM_LVL_DENY, 4'h6);
    ser(8'h78, cf(CAM_LVL_DENY, 2'h3, 4'hF) & 32'hFF);
    ser(CAM_CTRL_OFS, 32'h7);
    rq(32'h0A010203, CAM_PROTO_OTHER, 1'h1, CAM_LVL_DENY, 4'hF);
    close_out();
  end
endmodule : test_cam_matcher
